/* File: src/sig_insert_pkg.sv */
// Constants, register map and carrier types for the transmit signaling insert select block.
// Assumes one host clock domain and one backplane link clock domain.
// How it works
// - E1 CAS alignment/alarm byte and channel signaling may come from software registers.
// - E1: upper enable A bit 0 set sources upper alignment nibble from first signaling register.
// - E1: enable C bit 0 set sources lower alignment nibble from first signaling register.
// - E1: enable A bits 1-7 select software signaling for channels 1-7.
// - E1: enable B bits 0-7 select software signaling for channels 8-15.
// - E1: enable C bits 1-7 select software signaling for channels 16-22.
// - E1: enable D bits 0-7 select software signaling for channels 23-30.
// - Enable bit one takes channel signaling from software registers; zero does not.
// - T1 uses only enables A-C for 24 channels; enable D has no effect.
// - T1: enable A bits 0-7 select software signaling for channels 1-8.
// - T1: enable B bits 0-7 select software signaling for channels 9-16.
// - T1: enable C bits 0-7 select software signaling for channels 17-24.
// - Hardware mode buffers serial signaling input and inserts it into transmit data.
// - Hardware insertion is gated per channel by the hardware channel select.
// - Insertion works with the transmit elastic store enabled or bypassed.
// - E1 CAS signaling registers two onward: even channel upper, odd channel lower.
package sig_insert_pkg;

  localparam logic [7:0] ADDR_ENABLE_A  = 8'h08;
  localparam logic [7:0] ADDR_ENABLE_B  = 8'h09;
  localparam logic [7:0] ADDR_ENABLE_C  = 8'h0a;
  localparam logic [7:0] ADDR_ENABLE_D  = 8'h0b;
  localparam logic [7:0] ADDR_SIG_FIRST = 8'h50;
  localparam logic [7:0] ADDR_SIG_LAST  = 8'h5f;
  localparam logic [7:0] ENABLE_RESET   = 8'h00;
  localparam logic [7:0] SIG_RESET      = 8'h00;
  localparam logic [7:0] READ_UNMAPPED  = 8'h00;

  localparam int ALIGN_BIT        = 0;
  localparam logic [7:0] T1_FRAME_BITS = 8'd193;
  localparam logic [4:0] T1_MF_FRAMES  = 5'd24;
  localparam logic [4:0] E1_MF_FRAMES  = 5'd16;
  localparam logic [2:0] T1_SIG_PERIOD = 3'd6;
  localparam logic [4:0] E1_SIG_SLOT   = 5'd16;
  localparam logic [5:0] T1_UNITS      = 6'd24;
  localparam logic [5:0] E1_UNITS      = 6'd32;
  localparam int FIFO_WIDTH       = 4;
  localparam int FIFO_DEPTH       = 32;
  localparam int HS_BOUND         = 24;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wrData;
    logic       wrEn;
    logic       rdEn;
  } bus_req_t;

  typedef struct packed {
    logic [7:0]       enA;
    logic [7:0]       enB;
    logic [7:0]       enC;
    logic [7:0]       enD;
    logic [15:0][7:0] sigRegs;
  } sig_cfg_t;

endpackage

/* File: src/tx_signaling_insert_select.sv */
// Transmit signaling source selection: software registers, serial hardware stream or pass.
// Host bus is synchronous to mclk; serial streams and multiframe sync are on the link clock.
`timescale 1ns/10ps
`default_nettype none

module sig_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 32
) (
  input  wire logic                     clk,
  input  wire logic                     rstN,
  input  wire logic                     inValid,
  output logic                          inReady,
  input  wire logic [WIDTH-1:0]         inData,
  output logic                          outValid,
  input  wire logic                     outReady,
  output logic [WIDTH-1:0]              outData,
  output logic [$clog2(DEPTH):0]        count
);
  localparam int AW = $clog2(DEPTH);
  logic [DEPTH-1:0][WIDTH-1:0] mem_reg;
  logic [AW-1:0]               wrPtr_reg;
  logic [AW-1:0]               rdPtr_reg;
  logic [AW:0]                 count_reg;
  logic                        doPush;
  logic                        doPop;

  assign outValid = count_reg != '0;
  // Push is allowed into a full FIFO only when the head leaves in the same cycle
  assign inReady  = (count_reg != DEPTH[AW:0]) || outReady;
  assign doPush   = inValid && inReady;
  assign doPop    = outReady && outValid;
  assign outData  = mem_reg[rdPtr_reg];
  assign count    = count_reg;

  always_ff @(posedge clk or negedge rstN)
    if (!rstN)
      mem_reg <= '0;
    else if (doPush)
      mem_reg[wrPtr_reg] <= inData;

  always_ff @(posedge clk or negedge rstN)
    if (!rstN)
    begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (doPush)
        wrPtr_reg <= wrPtr_reg + 1'b1;
      if (doPop)
        rdPtr_reg <= rdPtr_reg + 1'b1;
      count_reg <= count_reg + {{AW{1'b0}}, doPush} - {{AW{1'b0}}, doPop};
    end
endmodule // sig_fifo

module tx_signaling_insert_select (
  input  wire logic                      mclk,
  input  wire logic                      rstn,
  input  wire sig_insert_pkg::bus_req_t  busReq,
  output logic [7:0]                     busRdData,
  input  wire logic                      txBackplaneClock,
  input  wire logic                      e1Mode,
  input  wire logic                      hwSigMode,
  input  wire logic [31:0]               hwSignalingChannelSelect,
  input  wire logic                      multiframeSync,
  input  wire logic                      txSerialDataIn,
  input  wire logic                      txSignalingSerialIn,
  output logic                           txSerialOut
);
  import sig_insert_pkg::*;

  localparam int HS_LIMIT = HS_BOUND;

  // Host side register file
  sig_cfg_t   cfg_reg;
  logic [7:0] busRdData_reg;
  logic       mapped;
  logic [3:0] sigIdx;

  assign sigIdx = busReq.addr[3:0];
  assign mapped = (busReq.addr >= ADDR_ENABLE_A && busReq.addr <= ADDR_ENABLE_D) ||
                  (busReq.addr >= ADDR_SIG_FIRST && busReq.addr <= ADDR_SIG_LAST);

  always_ff @(posedge mclk or negedge rstn)
    if (!rstn)
    begin
      cfg_reg.enA     <= ENABLE_RESET;
      cfg_reg.enB     <= ENABLE_RESET;
      cfg_reg.enC     <= ENABLE_RESET;
      cfg_reg.enD     <= ENABLE_RESET;
      cfg_reg.sigRegs <= {16{SIG_RESET}};
    end
    else if (busReq.wrEn)
    begin
      case (busReq.addr)
        ADDR_ENABLE_A: cfg_reg.enA <= busReq.wrData;
        ADDR_ENABLE_B: cfg_reg.enB <= busReq.wrData;
        ADDR_ENABLE_C: cfg_reg.enC <= busReq.wrData;
        ADDR_ENABLE_D: cfg_reg.enD <= busReq.wrData;
        default:
          if (busReq.addr >= ADDR_SIG_FIRST && busReq.addr <= ADDR_SIG_LAST)
            cfg_reg.sigRegs[sigIdx] <= busReq.wrData;
      endcase
    end

  always_ff @(posedge mclk or negedge rstn)
    if (!rstn)
      busRdData_reg <= READ_UNMAPPED;
    else if (busReq.rdEn)
    begin
      case (busReq.addr)
        ADDR_ENABLE_A: busRdData_reg <= cfg_reg.enA;
        ADDR_ENABLE_B: busRdData_reg <= cfg_reg.enB;
        ADDR_ENABLE_C: busRdData_reg <= cfg_reg.enC;
        ADDR_ENABLE_D: busRdData_reg <= cfg_reg.enD;
        default:
          busRdData_reg <= mapped ? cfg_reg.sigRegs[sigIdx] : READ_UNMAPPED;
      endcase
    end
  assign busRdData = busRdData_reg;

  // Configuration crosses as one snapshot under a toggle handshake
  sig_cfg_t snap_reg;
  logic     dirty_reg;
  logic     req_reg;
  logic     ackMeta_reg;
  logic     ackSync_reg;
  logic     ack_reg;
  logic     hsIdle;

  assign hsIdle = req_reg == ackSync_reg;

  always_ff @(posedge mclk or negedge rstn)
    if (!rstn)
    begin
      ackMeta_reg <= 1'b0;
      ackSync_reg <= 1'b0;
    end
    else
    begin
      ackMeta_reg <= ack_reg;
      ackSync_reg <= ackMeta_reg;
    end

  always_ff @(posedge mclk or negedge rstn)
    if (!rstn)
    begin
      snap_reg  <= '0;
      req_reg   <= 1'b0;
      dirty_reg <= 1'b0;
    end
    else
    begin
      if (hsIdle && dirty_reg)
      begin
        snap_reg <= cfg_reg;
        req_reg  <= ~req_reg;
      end
      // A write in the launch cycle keeps the dirty flag set
      if (busReq.wrEn && mapped)
        dirty_reg <= 1'b1;
      else if (hsIdle && dirty_reg)
        dirty_reg <= 1'b0;
    end

  // Link domain reset: asynchronous assert, synchronous release
  logic [1:0] linkRst_reg;
  logic       linkRstn;

  always_ff @(posedge txBackplaneClock or negedge rstn)
    if (!rstn)
      linkRst_reg <= 2'b00;
    else
      linkRst_reg <= {linkRst_reg[0], 1'b1};
  assign linkRstn = linkRst_reg[1];

  sig_cfg_t    linkCfg_reg;
  logic        reqMeta_reg;
  logic        reqSync_reg;
  logic [33:0] pinMeta_reg;
  logic [33:0] pinSync_reg;
  logic        e1L;
  logic        hwL;
  logic [31:0] hwSelL;

  always_ff @(posedge txBackplaneClock or negedge linkRstn)
    if (!linkRstn)
    begin
      reqMeta_reg <= 1'b0;
      reqSync_reg <= 1'b0;
      pinMeta_reg <= '0;
      pinSync_reg <= '0;
    end
    else
    begin
      reqMeta_reg <= req_reg;
      reqSync_reg <= reqMeta_reg;
      pinMeta_reg <= {e1Mode, hwSigMode, hwSignalingChannelSelect};
      pinSync_reg <= pinMeta_reg;
    end
  assign e1L    = pinSync_reg[33];
  assign hwL    = pinSync_reg[32];
  assign hwSelL = pinSync_reg[31:0];

  always_ff @(posedge txBackplaneClock or negedge linkRstn)
    if (!linkRstn)
    begin
      linkCfg_reg <= '0;
      ack_reg     <= 1'b0;
    end
    else if (reqSync_reg != ack_reg)
    begin
      linkCfg_reg <= snap_reg;
      ack_reg     <= reqSync_reg;
    end

  // Frame position
  logic [7:0] pos_reg;
  logic [4:0] frame_reg;
  logic [7:0] curPos;
  logic [4:0] curFrame;
  logic [7:0] slotBits;
  logic [4:0] slot;
  logic [2:0] bitIdx;
  logic       fBit;

  assign curPos   = multiframeSync ? 8'd0 : pos_reg;
  assign curFrame = multiframeSync ? 5'd0 : frame_reg;
  assign slotBits = e1L ? curPos : curPos - 8'd1;
  assign slot     = slotBits[7:3];
  assign bitIdx   = slotBits[2:0];
  assign fBit     = !e1L && curPos == 8'd0;

  always_ff @(posedge txBackplaneClock or negedge linkRstn)
    if (!linkRstn)
    begin
      pos_reg   <= 8'd0;
      frame_reg <= 5'd0;
    end
    else if (e1L ? curPos == 8'hff : curPos == T1_FRAME_BITS - 8'd1)
    begin
      pos_reg   <= 8'd0;
      frame_reg <= (curFrame == (e1L ? E1_MF_FRAMES : T1_MF_FRAMES) - 5'd1) ? 5'd0
                   : curFrame + 5'd1;
    end
    else
    begin
      pos_reg   <= curPos + 8'd1;
      frame_reg <= curFrame;
    end

  // Hardware stream is held one multiframe (E1) or one frame (T1) in the FIFO
  logic [2:0]            tsigShift_reg;
  logic                  hwUnit;
  logic                  primed;
  logic                  fifoInReady;
  logic                  fifoOutValid;
  logic [FIFO_WIDTH-1:0] fifoOut;
  logic [5:0]            fifoCount;
  logic                  fifoDrain;

  always_ff @(posedge txBackplaneClock or negedge linkRstn)
    if (!linkRstn)
      tsigShift_reg <= 3'b000;
    else
      tsigShift_reg <= {tsigShift_reg[1:0], txSignalingSerialIn};

  assign hwUnit = hwL && !fBit &&
                  (e1L ? (slot == E1_SIG_SLOT && bitIdx[1:0] == 2'd3) : bitIdx == 3'd7);
  assign primed = fifoOutValid && fifoCount == (e1L ? E1_UNITS : T1_UNITS);
  // Surplus units left by a switch to the shorter T1 period are dropped; otherwise the
  // FIFO sits full with no pop and hardware insertion stalls for good
  assign fifoDrain = (hwUnit && primed) || fifoCount > (e1L ? E1_UNITS : T1_UNITS);

  sig_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (txBackplaneClock),
    .rstN     (linkRstn),
    .inValid  (hwUnit),
    .inReady  (fifoInReady),
    .inData   ({tsigShift_reg, txSignalingSerialIn}),
    .outValid (fifoOutValid),
    .outReady (fifoDrain),
    .outData  (fifoOut),
    .count    (fifoCount)
  );

  // Per-bit source selection
  logic [29:0] swEnE1;
  logic [23:0] swEnT1;
  logic [4:0]  chan;
  logic        sigPos;
  logic [1:0]  nibBit;
  logic        swEn;
  logic        hwEn;
  logic [3:0]  swNib;
  logic [3:0]  regIdx;
  logic [7:0]  regVal;
  logic        outBit;
  logic        alignPos;
  logic        alignEn;
  logic [1:0]  t1Phase;

  assign swEnE1 = {linkCfg_reg.enD, linkCfg_reg.enC[7:1],
                   linkCfg_reg.enB, linkCfg_reg.enA[7:1]};
  assign swEnT1 = {linkCfg_reg.enC, linkCfg_reg.enB, linkCfg_reg.enA};
  assign t1Phase = 2'(curFrame / 5'(T1_SIG_PERIOD));

  always_comb
  begin
    chan     = 5'd0;
    sigPos   = 1'b0;
    nibBit   = 2'd0;
    alignPos = 1'b0;
    alignEn  = 1'b0;
    if (e1L)
    begin
      if (slot == E1_SIG_SLOT)
      begin
        nibBit = bitIdx[1:0];
        if (curFrame == 5'd0)
        begin
          alignPos = 1'b1;
          alignEn  = bitIdx[2] ? linkCfg_reg.enC[ALIGN_BIT]
                               : linkCfg_reg.enA[ALIGN_BIT];
        end
        else
        begin
          sigPos = 1'b1;
          chan   = bitIdx[2] ? curFrame + 5'd15 : curFrame;
        end
      end
    end
    else if (!fBit && bitIdx == 3'd7 &&
             curFrame % 5'(T1_SIG_PERIOD) == 5'(T1_SIG_PERIOD - 3'd1))
    begin
      sigPos = 1'b1;
      chan   = slot + 5'd1;
      nibBit = t1Phase;
    end
  end

  // E1 CAS packs odd channel low, even channel high, from the second register on
  assign regIdx = e1L ? 4'((chan + 5'd1) >> 1) : 4'((chan - 5'd1) >> 1);
  assign regVal = alignPos ? linkCfg_reg.sigRegs[0] : linkCfg_reg.sigRegs[regIdx];
  assign swNib  = (alignPos || !chan[0]) ? regVal[7:4] : regVal[3:0];
  assign swEn   = sigPos && (e1L ? swEnE1[chan - 5'd1] : swEnT1[chan - 5'd1]);
  assign hwEn   = sigPos && hwL && primed && hwSelL[chan - 5'd1];

  // Elastic store sits upstream; selection only sees bit position, so it is the same
  // whether the store is in circuit or bypassed
  always_comb
  begin
    outBit = txSerialDataIn;
    if (alignPos && alignEn)
      outBit = regVal[3'd7 - bitIdx];
    else if (swEn)
      outBit = swNib[2'd3 - nibBit];
    else if (hwEn)
      outBit = fifoOut[2'd3 - nibBit];
  end

  logic txSerialOut_reg;
  always_ff @(posedge txBackplaneClock or negedge linkRstn)
    if (!linkRstn)
      txSerialOut_reg <= 1'b0;
    else
      txSerialOut_reg <= outBit;
  assign txSerialOut = txSerialOut_reg;

  property p_rd_unmapped;
    @(posedge mclk) disable iff (!rstn)
    busReq.rdEn && !mapped |=> busRdData == READ_UNMAPPED;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

  property p_rd_enable_d;
    @(posedge mclk) disable iff (!rstn)
    busReq.wrEn && busReq.addr == ADDR_ENABLE_D ##2 busReq.rdEn && busReq.addr == ADDR_ENABLE_D
    |=> busRdData == $past(busReq.wrData, 3);
  endproperty
  a_rd_enable_d: assert property (p_rd_enable_d) else $error("enable D readback wrong");

  property p_handshake;
    @(posedge mclk) disable iff (!rstn)
    $changed(req_reg) |-> ##[1:HS_LIMIT] (ackSync_reg == req_reg);
  endproperty
  a_handshake: assert property (p_handshake) else $error("config transfer not acknowledged");

  property p_upper_align;
    @(posedge txBackplaneClock) disable iff (!linkRstn)
    e1L && alignPos && !bitIdx[2] && linkCfg_reg.enA[ALIGN_BIT]
    |=> txSerialOut == $past(linkCfg_reg.sigRegs[0][3'd7 - bitIdx]);
  endproperty
  a_upper_align: assert property (p_upper_align) else $error("upper align nibble wrong");

  property p_lower_align;
    @(posedge txBackplaneClock) disable iff (!linkRstn)
    e1L && alignPos && bitIdx[2] && linkCfg_reg.enC[ALIGN_BIT]
    |=> txSerialOut == $past(linkCfg_reg.sigRegs[0][3'd7 - bitIdx]);
  endproperty
  a_lower_align: assert property (p_lower_align) else $error("lower align nibble wrong");

  property p_pass;
    @(posedge txBackplaneClock) disable iff (!linkRstn)
    !(alignPos && alignEn) && !swEn && !hwEn |=> txSerialOut == $past(txSerialDataIn);
  endproperty
  a_pass: assert property (p_pass) else $error("unselected bit not passed");

  property p_t1_enable_d;
    @(posedge txBackplaneClock) disable iff (!linkRstn)
    !e1L && sigPos && !swEnT1[chan - 5'd1] && !hwEn |=> txSerialOut == $past(txSerialDataIn);
  endproperty
  a_t1_enable_d: assert property (p_t1_enable_d) else $error("T1 used a disabled channel");

  property p_sw_channel;
    @(posedge txBackplaneClock) disable iff (!linkRstn)
    swEn && !alignPos |=> txSerialOut == $past(swNib[2'd3 - nibBit]);
  endproperty
  a_sw_channel: assert property (p_sw_channel) else $error("software signaling bit wrong");

  property p_hw_channel;
    @(posedge txBackplaneClock) disable iff (!linkRstn)
    hwEn && !swEn && !alignPos |=> txSerialOut == $past(fifoOut[2'd3 - nibBit]);
  endproperty
  a_hw_channel: assert property (p_hw_channel) else $error("hardware signaling bit wrong");

  property p_fifo_level;
    @(posedge txBackplaneClock) disable iff (!linkRstn)
    hwUnit && primed |=> fifoCount == $past(fifoCount);
  endproperty
  a_fifo_level: assert property (p_fifo_level) else $error("FIFO delay not held");

endmodule // tx_signaling_insert_select
`default_nettype wire

/* File: tb/backplane_model.sv */
// Backplane source model: frame-aligned transmit data, serial signaling and multiframe sync.
// Assumes a free-running link clock and per-position bit patterns supplied by the bench.
`timescale 1ns/10ps
`default_nettype none

module backplane_model (
  input  wire logic         linkClk,
  input  wire logic         rstn,
  input  wire logic         run,
  input  wire logic         e1Sel,
  input  wire logic [255:0] dataPat,
  input  wire logic [255:0] sigPat,
  output logic              dataOut,
  output logic              sigOut,
  output logic              mfSync,
  output logic [4:0]        frameIdx,
  output logic [7:0]        bitPos
);
  logic e1Last;

  // A mode change restarts the multiframe so the far end can resync on the next pulse
  always_ff @(posedge linkClk or negedge rstn)
  begin
    if (!rstn)
    begin
      frameIdx <= 5'h00;
      bitPos   <= 8'h00;
      e1Last   <= 1'b1;
    end
    else if (!run || e1Sel != e1Last)
    begin
      frameIdx <= 5'h00;
      bitPos   <= 8'h00;
      e1Last   <= e1Sel;
    end
    else if (bitPos == (e1Sel ? 8'hff : 8'hc0))
    begin
      bitPos   <= 8'h00;
      frameIdx <= (frameIdx == (e1Sel ? 5'h0f : 5'h17)) ? 5'h00 : frameIdx + 5'h01;
    end
    else
      bitPos <= bitPos + 8'h01;
  end

  // The signaling pattern depends on position only, so delayed hardware signaling still lines up
  assign dataOut = run & (dataPat[bitPos] ^ frameIdx[0]);
  assign sigOut  = run & sigPat[bitPos];
  assign mfSync  = run && frameIdx == 5'h00 && bitPos == 8'h00;
endmodule // backplane_model

`default_nettype wire

/* File: tb/tx_signaling_insert_select_tb.sv */
// Self-checking bench for transmit signaling source selection, E1 and T1 framing.
// Assumes the backplane model in tb/ and the design package and module in src/.
`timescale 1ns/10ps
`default_nettype none

module tx_signaling_insert_select_tb;
  import sig_insert_pkg::*;

  typedef struct {
    time  stamp;
    logic val;
  } note_t;

  logic         mclk;
  logic         linkClk;
  logic         rstn;
  bus_req_t     busReq;
  logic [7:0]   busRdData;
  logic         e1Mode;
  logic         hwSigMode;
  logic [31:0]  hwSel;
  logic         run;
  logic [255:0] dataPat;
  logic [255:0] sigPat;
  logic         dataLine;
  logic         sigLine;
  logic         mfSync;
  logic [4:0]   frameIdx;
  logic [7:0]   bitPos;
  logic         txSerialOut;
  logic         checking;
  logic         rdFlag;
  logic [7:0]   mirA, mirB, mirC, mirD;
  logic [7:0]   mirSig [16];
  logic [31:0]  mask;
  int           fails;
  int           checked;
  int           seed;
  note_t        expQ [$];
  logic [7:0]   rdQ [$];
  note_t        note;

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  initial
  begin
    linkClk = 1'b0;
    #10;
    // Elastic store stays bypassed here, so the backplane rate limit is not at stake
    forever #62.5 linkClk = ~linkClk;
  end

  tx_signaling_insert_select dut (
    .mclk                     (mclk),
    .rstn                     (rstn),
    .busReq                   (busReq),
    .busRdData                (busRdData),
    .txBackplaneClock         (linkClk),
    .e1Mode                   (e1Mode),
    .hwSigMode                (hwSigMode),
    .hwSignalingChannelSelect (hwSel),
    .multiframeSync           (mfSync),
    .txSerialDataIn           (dataLine),
    .txSignalingSerialIn      (sigLine),
    .txSerialOut              (txSerialOut)
  );

  backplane_model partner (
    .linkClk  (linkClk),
    .rstn     (rstn),
    .run      (run),
    .e1Sel    (e1Mode),
    .dataPat  (dataPat),
    .sigPat   (sigPat),
    .dataOut  (dataLine),
    .sigOut   (sigLine),
    .mfSync   (mfSync),
    .frameIdx (frameIdx),
    .bitPos   (bitPos)
  );

  task automatic check(input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t exp %h got %h", $time, exp, got);
    end
  endtask

  task automatic wrap_up();
    if (fails == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Expected output bit for the bit the model presents at frame f, position p
  function automatic logic expBit(input logic [4:0] f, input logic [7:0] p, input logic d);
    int          k;
    int          ch;
    logic [29:0] e1En;
    logic [23:0] t1En;
    logic [7:0]  r;
    e1En   = {mirD, mirC[7:1], mirB, mirA[7:1]};
    t1En   = {mirC, mirB, mirA};
    k      = int'(p) - 128;
    expBit = d;
    if (e1Mode && k >= 0 && k < 8)
    begin
      if (f == 5'h00)
      begin
        if (k < 4 && mirA[0])
          expBit = mirSig[0][7 - k];
        if (k >= 4 && mirC[0])
          expBit = mirSig[0][7 - k];
      end
      else
      begin
        ch = (k < 4) ? int'(f) : int'(f) + 15;
        r  = mirSig[(ch + 1) / 2];
        if (e1En[ch - 1])
          expBit = r[(ch % 2 == 0 ? 7 : 3) - k % 4];
        else if (hwSigMode && hwSel[ch - 1])
          expBit = sigPat[p];
      end
    end
    else if (!e1Mode && p != 8'h00 && f % 6 == 5 && p % 8 == 0)
    begin
      ch = int'(p) / 8;
      k  = int'(f) / 6;
      r  = mirSig[(ch - 1) / 2];
      if (t1En[ch - 1])
        expBit = r[(ch % 2 == 0 ? 7 : 3) - k];
      else if (hwSigMode && hwSel[ch - 1])
        expBit = sigPat[int'(p) - 3 + k];
    end
  endfunction

  task automatic busWrite(input logic [7:0] a, input logic [7:0] d);
    busReq <= '{addr: a, wrData: d, wrEn: 1'b1, rdEn: 1'b0};
    @(posedge mclk);
    busReq.wrEn <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic busRead(input logic [7:0] a, input logic [7:0] e);
    rdQ.push_back(e);
    busReq <= '{addr: a, wrData: 8'h00, wrEn: 1'b0, rdEn: 1'b1};
    @(posedge mclk);
    busReq.rdEn <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic setEn(input logic [31:0] v);
    {mirD, mirC, mirB, mirA} = v;
    for (int i = 0; i < 4; i++)
    begin
      busWrite(ADDR_ENABLE_A + 8'(i), v[8*i +: 8]);
      busRead(ADDR_ENABLE_A + 8'(i), v[8*i +: 8]);
    end
  endtask

  // Checks exactly one multiframe, starting just after a sync pulse
  task automatic checkMf();
    @(posedge linkClk iff mfSync);
    @(negedge linkClk);
    checking = 1'b1;
    @(posedge linkClk iff mfSync);
    @(negedge linkClk);
    checking = 1'b0;
    // Lets the last note of the multiframe be compared before anything moves on
    @(negedge linkClk);
    @(posedge mclk);
  endtask

  always @(posedge mclk)
  begin
    if (rdFlag && rdQ.size() > 0)
      check(rdQ.pop_front(), busRdData);
    rdFlag <= busReq.rdEn;
  end

  always @(posedge linkClk)
    if (checking)
      expQ.push_back('{stamp: $time, val: expBit(frameIdx, bitPos, dataLine)});

  // Notes from the current edge wait one link cycle for the registered output
  always @(posedge linkClk)
    if (expQ.size() > 0 && expQ[0].stamp < $time)
    begin
      note = expQ.pop_front();
      check({7'h00, note.val}, {7'h00, txSerialOut});
    end

  initial
  begin
    repeat (90000) @(posedge mclk);
    fails++;
    wrap_up();
  end

  initial
  begin
    seed      = 99308;
    fails     = 0;
    checked   = 0;
    rstn      = 1'b0;
    run       = 1'b0;
    checking  = 1'b0;
    rdFlag    = 1'b0;
    e1Mode    = 1'b1;
    hwSigMode = 1'b0;
    hwSel     = 32'h0000_0000;
    busReq    = '0;
    for (int i = 0; i < 8; i++)
    begin
      dataPat[32*i +: 32] = $random(seed);
      sigPat[32*i +: 32]  = $random(seed);
    end
    // Held for three link cycles so both domains see at least two edges in reset
    repeat (3) @(posedge linkClk);
    @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    check(8'h00, busRdData);
    for (int i = 0; i < 4; i++)
      busRead(ADDR_ENABLE_A + 8'(i), ENABLE_RESET);
    busWrite(8'h20, 8'ha5);
    busRead(8'h20, READ_UNMAPPED);
    for (int i = 0; i < 16; i++)
    begin
      mirSig[i] = 8'($random(seed));
      busWrite(ADDR_SIG_FIRST + 8'(i), mirSig[i]);
      busRead(ADDR_SIG_FIRST + 8'(i), mirSig[i]);
    end
    @(posedge linkClk);
    run <= 1'b1;
    @(posedge mclk);
    // Hardware mode on with no channel selected: only software or pass-through may appear
    // No elastic store in front, so the host control bit that must stay clear is never set
    hwSigMode <= 1'b1;
    mask = $random(seed);
    setEn(mask);
    checkMf();
    // Complemented enables flip every bit, hardware now fills the channels left clear whose random hwSel bit is set
    hwSel <= $random(seed);
    setEn(~mask);
    checkMf();
    // T1 with a nonzero fourth enable, which must not matter
    e1Mode <= 1'b0;
    hwSel  <= $random(seed);
    setEn($random(seed));
    checkMf();
    wrap_up();
  end
endmodule // tx_signaling_insert_select_tb

`default_nettype wire
